// ===== core/ioxp_top.sv
/*
  I2C eight-bit I/O expander top: bus target engine with command pointer,
  instantiating the condition detector and the port register file.
  Assumes SCL/SDA and straps are synchronous to clk_i and the bus clock is
  far slower than clk_i (several clocks per SCL phase).
  Each SCL phase must last at least four system clocks,
  since events and the SDA sample both lag the pins by one clock.
  There is no spike filter: a glitch on SCL or SDA that
  lasts a whole clock is taken as a real edge.
  The pointer never auto-increments; every read or write
  after the command targets the same register.
  Strap levels are read only at the end of the address.
*/
`timescale 1ns/1ps
module ioxp_top
  import ioxp_pkg::*;
#(
  parameter int WIDTH = 8  // Port width
) (
  input  wire logic             clk_i,           // 50 MHz system clock
  input  wire logic             sys_rst_i,       // Power-on reset, active high
  input  wire logic             scl_i,           // Bus clock level
  input  wire logic             sda_i,           // Bus data level
  output logic                  sda_o,           // Bus data drive value, always 0
  output logic                  sda_oe_o,        // High while pulling SDA low
  input  wire logic             addr_strap_lsb,  // Address strap bit 0
  input  wire logic             addr_strap_mid,  // Address strap bit 1
  input  wire logic             addr_strap_msb,  // Address strap bit 2
  input  wire logic [WIDTH-1:0] port_pins_i,     // Pin levels
  output logic      [WIDTH-1:0] port_pins_o,     // Pin drive values
  output logic      [WIDTH-1:0] port_pins_oe_o   // Pin driver enables
);
  ioxp_bus_ev_t ev;               // Bus events
  ioxp_wr_t     wr_reg;           // Register write request
  ioxp_state_t  state_reg;        // Engine state
  logic [3:0]   bit_cnt_reg;      // Bits taken in current byte
  logic [7:0]   shift_reg;        // Receive or transmit shifter
  logic [7:0]   ptr_reg;          // Stored command byte
  logic         cmd_pending_reg;  // Next written byte is a command
  logic         rnw_reg;          // Read direction latched
  logic         master_nack_reg;  // Master declined last read byte
  logic [7:0]   rd_data;          // Selected register value

  // Own address from fixed bits and straps
  function automatic logic addr_match(input logic [6:0] a, input logic [2:0] s);
    addr_match = (a == {IOXP_ADDR_FIXED, s});
  endfunction : addr_match

  ioxp_bus_cond u_cond (
    .clk_i    (clk_i),
    .sys_rst_i(sys_rst_i),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .ev_o     (ev)
  );

  ioxp_port_regs #(.WIDTH(WIDTH)) u_regs (
    .clk_i    (clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_i     (wr_reg),
    .rd_sel_i (ptr_reg[1:0]),
    .rd_data_o(rd_data),
    .pins_i   (port_pins_i),
    .pins_o   (port_pins_o),
    .pins_oe_o(port_pins_oe_o)
  );

  // Main engine: start always restarts, stop always returns to idle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg       <= IOXP_ST_IDLE;
      bit_cnt_reg     <= 4'h0;
      shift_reg       <= 8'h00;
      rnw_reg         <= 1'b0;
      cmd_pending_reg <= 1'b0;
      master_nack_reg <= 1'b0;
    end else if (ev.start) begin
      state_reg   <= IOXP_ST_ADDR;
      bit_cnt_reg <= 4'h0;
    end else if (ev.stop) begin
      state_reg <= IOXP_ST_IDLE;
    end else begin
      case (state_reg)
        IOXP_ST_ADDR: begin
          // Bits shifted in MSB first on rising SCL
          if (ev.rise) begin
            shift_reg   <= {shift_reg[6:0], ev.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (ev.fall && bit_cnt_reg == 4'(IOXP_BYTE_BITS)) begin
            bit_cnt_reg <= 4'h0;
            if (addr_match(shift_reg[7:1], {addr_strap_msb, addr_strap_mid, addr_strap_lsb})) begin
              rnw_reg         <= shift_reg[0];
              cmd_pending_reg <= ~shift_reg[0];
              state_reg       <= IOXP_ST_AACK;
            end else begin
              state_reg <= IOXP_ST_IDLE;
            end
          end
        end
        IOXP_ST_AACK: begin
          // Ack slot ends on the falling edge of the ninth pulse
          if (ev.fall) begin
            if (rnw_reg) begin
              shift_reg <= rd_data;
              state_reg <= IOXP_ST_RD;
            end else begin
              state_reg <= IOXP_ST_WR;
            end
          end
        end
        IOXP_ST_WR: begin
          // Command or data bits, MSB first on rising SCL
          if (ev.rise) begin
            shift_reg   <= {shift_reg[6:0], ev.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (ev.fall && bit_cnt_reg == 4'(IOXP_BYTE_BITS)) begin
            bit_cnt_reg     <= 4'h0;
            cmd_pending_reg <= 1'b0;
            state_reg       <= IOXP_ST_WACK;
          end
        end
        IOXP_ST_WACK: begin
          // Ack held until the ninth pulse falls
          if (ev.fall) begin
            state_reg <= IOXP_ST_WR;
          end
        end
        IOXP_ST_RD: begin
          // Next bit presented on falling SCL, counted on rising
          if (ev.rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (ev.fall) begin
            if (bit_cnt_reg == 4'(IOXP_BYTE_BITS)) begin
              bit_cnt_reg <= 4'h0;
              state_reg   <= IOXP_ST_RACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        IOXP_ST_RACK: begin
          // Master answer taken at rising SCL, acted on at fall
          if (ev.rise) begin
            master_nack_reg <= ev.sda;
          end else if (ev.fall) begin
            if (master_nack_reg) begin
              state_reg <= IOXP_ST_IDLE;
            end else begin
              shift_reg <= rd_data;
              state_reg <= IOXP_ST_RD;
            end
          end
        end
        // Idle and unused codes wait for the next start
        default: state_reg <= IOXP_ST_IDLE;
      endcase
    end
  end

  // Command pointer and register writes, taken at the end of each written byte
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ptr_reg <= IOXP_RST_PTR;
      wr_reg  <= '{we: 1'b0, sel: 2'h0, data: 8'h00};
    end else begin
      wr_reg.we <= 1'b0;
      if (!ev.start && !ev.stop && state_reg == IOXP_ST_WR && ev.fall
          && bit_cnt_reg == 4'(IOXP_BYTE_BITS)) begin
        if (cmd_pending_reg) begin
          ptr_reg <= shift_reg;
        end else begin
          wr_reg <= '{we: 1'b1, sel: ptr_reg[1:0], data: shift_reg};
        end
      end
    end
  end

  // SDA drive: acks pull low; read bits pull low for zeros; released otherwise
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      case (state_reg)
        IOXP_ST_AACK: sda_oe_o <= 1'b1;
        IOXP_ST_WACK: sda_oe_o <= 1'b1;
        IOXP_ST_RD:   sda_oe_o <= ~shift_reg[7];
        default:      sda_oe_o <= 1'b0;
      endcase
    end
  end

  // End of an eighth bit with no control condition beside it
  logic byte_end;  // Byte boundary seen by the engine
  assign byte_end = ev.fall
    && (bit_cnt_reg == 4'(IOXP_BYTE_BITS))
    && !ev.start
    && !ev.stop;

  // Ack held low through the whole high phase of the ninth pulse
  ack_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == IOXP_ST_AACK && ev.rise)
    |=> sda_oe_o)
    else $error("Address ack not driven during ninth pulse");

  // Nothing on SDA once the engine has let go of the bus
  foreign_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == IOXP_ST_IDLE)
    |=> !sda_oe_o)
    else $error("SDA driven while idle");

  // Master owns SDA in its own ack slot
  nack_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == IOXP_ST_RACK && !ev.start && !ev.stop)
    |=> !sda_oe_o)
    else $error("SDA not released in master ack slot");

  // Stop always ends the transaction
  stop_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev.stop && !ev.start)
    |=> (state_reg == IOXP_ST_IDLE))
    else $error("Stop did not return engine to idle");

  // Start always reopens the address phase
  start_addr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ev.start
    |=> (state_reg == IOXP_ST_ADDR && bit_cnt_reg == 4'h0))
    else $error("Start did not open address phase");

  // Pointer only moves at a command byte
  ptr_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg != IOXP_ST_WR)
    |=> $stable(ptr_reg))
    else $error("Pointer changed outside write phase");

  // Writes go where the pointer points
  write_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_reg.we
    |-> (wr_reg.sel == ptr_reg[1:0]))
    else $error("Write target differs from pointer");

  // Every stored byte is followed by an ack
  wr_ack_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_reg.we
    |-> ##[0:2] sda_oe_o)
    else $error("Stored byte not acknowledged");

  // Command byte lands in the pointer, never in a register
  ptr_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == IOXP_ST_WR && byte_end && cmd_pending_reg)
    |=> (ptr_reg == $past(shift_reg) && !wr_reg.we))
    else $error("Command byte not stored in pointer");

  // Data byte handed on whole to the register file
  data_store_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == IOXP_ST_WR && byte_end && !cmd_pending_reg)
    |=> (wr_reg.we && wr_reg.data == $past(shift_reg)))
    else $error("Data byte not handed to registers");

  // Received bytes acked through the ninth high phase
  wack_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == IOXP_ST_WACK && ev.rise)
    |=> sda_oe_o)
    else $error("Data ack not driven during ninth pulse");

  // Read bit on SDA while SCL is high
  rd_bit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == IOXP_ST_RD && ev.rise)
    |=> (sda_oe_o == !$past(shift_reg[7])))
    else $error("Read bit not on SDA at rising SCL");

  // Foreign address drops the engine back to idle
  addr_drop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == IOXP_ST_ADDR && byte_end
     && !addr_match(shift_reg[7:1], {addr_strap_msb, addr_strap_mid, addr_strap_lsb}))
    |=> (state_reg == IOXP_ST_IDLE))
    else $error("Foreign address not ignored");

  // Read starts from the register the pointer selects
  rd_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == IOXP_ST_AACK && ev.fall && rnw_reg && !ev.start && !ev.stop)
    |=> (shift_reg == $past(rd_data)))
    else $error("Read byte not from selected register");

  // Full read byte followed by the master slot
  read_cover: cover property (@(posedge clk_i)
    state_reg == IOXP_ST_RD ##1 state_reg == IOXP_ST_RACK);
  // A data byte written
  write_cover: cover property (@(posedge clk_i) wr_reg.we);
  // Read ended by the master
  nack_cover: cover property (@(posedge clk_i)
    state_reg == IOXP_ST_RACK && master_nack_reg && ev.fall);
  // Address of another device skipped
  foreign_cover: cover property (@(posedge clk_i)
    (state_reg == IOXP_ST_ADDR && byte_end) ##1 state_reg == IOXP_ST_IDLE);
  // Repeated start inside a write
  restart_cover: cover property (@(posedge clk_i)
    ev.start && state_reg == IOXP_ST_WR);
endmodule : ioxp_top

// ===== core/ioxp_pkg.sv
/*
  Package for the I2C eight-bit I/O expander: register indices, reset values,
  address layout, bus states and the packed carriers shared by the design files.
  Assumes a single 50 MHz clock domain and synchronous active-high reset.
*/
package ioxp_pkg;
  // Register indices selected by the two low command bits
  localparam logic [1:0] IOXP_REG_INPUT  = 2'h0;  // Input level, read only
  localparam logic [1:0] IOXP_REG_OUTPUT = 2'h1;  // Output latch
  localparam logic [1:0] IOXP_REG_INVERT = 2'h2;  // Input polarity invert
  localparam logic [1:0] IOXP_REG_DIR    = 2'h3;  // Pin direction

  // Reset values
  localparam logic [7:0] IOXP_RST_OUTPUT = 8'hFF;  // Latch all ones
  localparam logic [7:0] IOXP_RST_INVERT = 8'h00;  // No inversion
  localparam logic [7:0] IOXP_RST_DIR    = 8'hFF;  // All pins inputs
  localparam logic [7:0] IOXP_RST_PTR    = 8'h00;  // Command pointer

  // Fixed upper address bits; straps fill the low three
  localparam logic [3:0] IOXP_ADDR_FIXED = 4'h7;
  localparam int         IOXP_BYTE_BITS  = 8;      // Bits per byte before ack

  // Bus engine states
  typedef enum logic [2:0] {
    IOXP_ST_IDLE = 3'b000,  // Waiting for a start
    IOXP_ST_ADDR = 3'b001,  // Shifting address byte
    IOXP_ST_AACK = 3'b010,  // Address acknowledge slot
    IOXP_ST_WR   = 3'b011,  // Receiving command or data byte
    IOXP_ST_WACK = 3'b100,  // Acknowledge of a written byte
    IOXP_ST_RD   = 3'b101,  // Transmitting a byte
    IOXP_ST_RACK = 3'b110   // Master acknowledge slot
  } ioxp_state_t;

  // Conditioned bus events from the edge detector
  typedef struct packed {
    logic start;  // SDA fell while SCL high
    logic stop;   // SDA rose while SCL high
    logic rise;   // SCL rising edge
    logic fall;   // SCL falling edge
    logic sda;    // Current SDA level
  } ioxp_bus_ev_t;

  // Register write request from the bus engine
  typedef struct packed {
    logic       we;    // One-cycle write strobe
    logic [1:0] sel;   // Target register
    logic [7:0] data;  // Byte to store
  } ioxp_wr_t;
endpackage : ioxp_pkg

// ===== core/ioxp_bus_cond.sv
/*
  Bus condition detector: registers SCL and SDA once, then reports start,
  stop and clock edges as one-cycle pulses. Inputs are taken as synchronous.
*/
`timescale 1ns/1ps
module ioxp_bus_cond
  import ioxp_pkg::*;
(
  input  wire logic   clk_i,      // System clock
  input  wire logic   sys_rst_i,  // Synchronous reset
  input  wire logic   scl_i,      // Bus clock level
  input  wire logic   sda_i,      // Bus data level
  output ioxp_bus_ev_t ev_o       // Registered event pulses
);
  logic scl_reg;  // Previous SCL
  logic sda_reg;  // Previous SDA

  // Sample history; idle bus reads high so reset to one
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl_i;
      sda_reg <= sda_i;
    end
  end

  // Event pulses; SDA moving while SCL high is a control condition
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ev_o <= '{start: 1'b0, stop: 1'b0, rise: 1'b0, fall: 1'b0, sda: 1'b1};
    end else begin
      ev_o.start <= scl_reg & scl_i & sda_reg & ~sda_i;
      ev_o.stop  <= scl_reg & scl_i & ~sda_reg & sda_i;
      ev_o.rise  <= ~scl_reg & scl_i;
      ev_o.fall  <= scl_reg & ~scl_i;
      ev_o.sda   <= sda_i;
    end
  end
endmodule : ioxp_bus_cond

// ===== core/ioxp_port_regs.sv
/*
  Port register file: output latch, polarity invert and direction registers,
  pin drivers and the read mux. Expects one-cycle write strobes.
*/
`timescale 1ns/1ps
module ioxp_port_regs
  import ioxp_pkg::*;
#(
  parameter int WIDTH = 8  // Port width
) (
  input  wire logic             clk_i,      // System clock
  input  wire logic             sys_rst_i,  // Synchronous reset
  input  ioxp_wr_t              wr_i,       // Write request
  input  wire logic [1:0]       rd_sel_i,   // Register to read
  output logic      [7:0]       rd_data_o,  // Read byte, registered
  input  wire logic [WIDTH-1:0] pins_i,     // Pin levels
  output logic      [WIDTH-1:0] pins_o,     // Pin drive values
  output logic      [WIDTH-1:0] pins_oe_o   // Driver enables
);
  logic [WIDTH-1:0] output_latch_reg;           // Output latch
  logic [WIDTH-1:0] input_polarity_invert_reg;  // Inversion bits
  logic [WIDTH-1:0] pin_direction_reg;          // 1 = input
  logic [WIDTH-1:0] input_level_reg;            // Sampled pin levels

  // Software-writable registers; writes to the input level register are dropped
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      output_latch_reg          <= IOXP_RST_OUTPUT[WIDTH-1:0];
      input_polarity_invert_reg <= IOXP_RST_INVERT[WIDTH-1:0];
      pin_direction_reg         <= IOXP_RST_DIR[WIDTH-1:0];
    end else if (wr_i.we) begin
      if (wr_i.sel == IOXP_REG_OUTPUT) begin
        output_latch_reg <= wr_i.data[WIDTH-1:0];
      end else if (wr_i.sel == IOXP_REG_INVERT) begin
        input_polarity_invert_reg <= wr_i.data[WIDTH-1:0];
      end else if (wr_i.sel == IOXP_REG_DIR) begin
        pin_direction_reg <= wr_i.data[WIDTH-1:0];
      end
      // Input level target: no effect
    end
  end

  // Input sampling; inversion applies only to pins set as inputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      input_level_reg <= '0;
    end else begin
      input_level_reg <= pins_i ^ (input_polarity_invert_reg & pin_direction_reg);
    end
  end

  // Read mux; latch reads return the flip-flops, not pin levels
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      case (rd_sel_i)
        IOXP_REG_INPUT:  rd_data_o <= 8'(input_level_reg);
        IOXP_REG_OUTPUT: rd_data_o <= 8'(output_latch_reg);
        IOXP_REG_INVERT: rd_data_o <= 8'(input_polarity_invert_reg);
        default:         rd_data_o <= 8'(pin_direction_reg);
      endcase
    end
  end

  // Drivers: inputs float, outputs push the latch level
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pins_oe_o <= '0;
      pins_o    <= '0;
    end else begin
      pins_oe_o <= ~pin_direction_reg;
      pins_o    <= output_latch_reg & ~pin_direction_reg;
    end
  end

  // Input pin never driven one cycle after its direction bit is set
  dir_float_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 (pins_oe_o == ~$past(pin_direction_reg)))
    else $error("Driver enable does not follow direction");
  latch_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 ((pins_o & pins_oe_o) == ($past(output_latch_reg) & pins_oe_o)))
    else $error("Driven level differs from latch");
endmodule : ioxp_port_regs

// ===== sim/ioxp_master_model.sv
/*
  Bus master model for the expander: drives SCL and the low side of SDA,
  reports each received acknowledge or byte as a one-cycle result pulse.
  Assumes the bench resolves SDA as open drain with a pull-up.
*/
`timescale 1ns/1ps
module ioxp_master_model #(
  parameter int PHASE = 5  // Clocks per SCL phase, design needs at least 4
) (
  input  wire logic       clk_i,      // System clock
  input  wire logic       sda_i,      // Resolved SDA level
  output logic            scl_o,      // Bus clock, high while idle
  output logic            sda_low_o,  // High while pulling SDA low
  output logic            rx_vld_o,   // One-cycle result pulse
  output logic            rx_ack_o,   // Result is an acknowledge bit
  output logic      [7:0] rx_data_o   // Result value
);
  // Idle bus at time zero
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
    rx_vld_o  = 1'b0;
    rx_ack_o  = 1'b0;
    rx_data_o = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // Hand a result to the bench watcher for one cycle
  task automatic report(input logic is_ack, input logic [7:0] val);
    rx_ack_o  <= is_ack;
    rx_data_o <= val;
    rx_vld_o  <= 1'b1;
    tick(1);
    rx_vld_o  <= 1'b0;
  endtask : report
  // SDA moves at least two clocks after the SCL fall, never while SCL is high
  task automatic put_bit(input logic b);
    sda_low_o <= ~b;
    tick(PHASE);
    scl_o <= 1'b1;
    tick(PHASE);
    scl_o <= 1'b0;
    tick(2);
  endtask : put_bit
  // Release SDA first so the other side may drive the bit
  task automatic get_bit(output logic b);
    sda_low_o <= 1'b0;
    tick(PHASE);
    scl_o <= 1'b1;
    tick(PHASE);
    b = sda_i;
    scl_o <= 1'b0;
    tick(2);
  endtask : get_bit
  // Start from idle, or repeated start from the low phase after an ack
  task automatic bus_start();
    sda_low_o <= 1'b0;
    tick(PHASE);
    scl_o <= 1'b1;
    tick(PHASE);
    sda_low_o <= 1'b1;
    tick(PHASE);
    scl_o <= 1'b0;
    tick(PHASE);
  endtask : bus_start
  task automatic bus_stop();
    sda_low_o <= 1'b1;
    tick(PHASE);
    scl_o <= 1'b1;
    tick(PHASE);
    sda_low_o <= 1'b0;
    tick(PHASE);
  endtask : bus_stop
  task automatic send_byte(input logic [7:0] data, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(data[i]);
    end
    get_bit(ack);
    report(1'b1, {7'h00, ack});
  endtask : send_byte
  // Master acks every byte but the last, which it leaves high
  task automatic recv_byte(input logic last);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    report(1'b0, d);
    put_bit(last);
  endtask : recv_byte
endmodule : ioxp_master_model

// ===== sim/ioxp_top_bench.sv
/*
  Self-checking bench for the expander top: queues expected bus results,
  a watcher compares them as the master model reports them.
  Assumes the master model in ioxp_master_model.sv and a 50 MHz clock.
*/
`timescale 1ns/1ps
module ioxp_top_bench;
  import ioxp_pkg::*;
  localparam int LIMIT = 90000;  // Cycle ceiling, about eight times the run
  logic       clk_i, sys_rst_i, scl, sda_low, sda_o, sda_oe_o, rx_vld, rx_ack, dummy;
  logic [7:0] rx_data, pins_o, pins_oe, pins_ext, dir, inv, d1, d2;
  logic [2:0] strap;     // Address strap levels
  logic [8:0] exp_q[$];  // Expected results, bit 8 marks an acknowledge
  logic [8:0] note;      // Oldest expectation
  int         err_total, num_checks, cyc, seed;
  wire logic       sda  = (sda_oe_o ? sda_o : 1'b1) & ~sda_low;           // Pull-up when released
  wire logic [7:0] pins = (pins_oe & pins_o) | (~pins_oe & pins_ext);    // Driven pins win

  ioxp_top #(.WIDTH(8)) u_ioxp_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_lsb(strap[0]), .addr_strap_mid(strap[1]),
    .addr_strap_msb(strap[2]), .port_pins_i(pins), .port_pins_o(pins_o), .port_pins_oe_o(pins_oe));
  ioxp_master_model #(.PHASE(5)) u_ioxp_master_model (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(sda_low), .rx_vld_o(rx_vld), .rx_ack_o(rx_ack), .rx_data_o(rx_data));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_byte
  task automatic check_ack(input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] ack expected %b seen %b", exp, got);
    end
  endtask : check_ack
  task automatic end_of_test();
    if (exp_q.size() != 0) begin
      err_total++;
      $display("[ERR] result_queue expected 0 seen %0d", exp_q.size());
    end
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // Watcher: each reported result takes the oldest note
  always @(posedge clk_i) begin
    if (rx_vld === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[ERR] result_queue expected empty seen %h", rx_data);
      end else begin
        note = exp_q.pop_front();
        if (note[8]) begin
          check_ack(note[0], rx_data[0]);
        end else begin
          check_byte("read_byte", note[7:0], rx_data);
        end
      end
    end
  end
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      end_of_test();
    end
  end
  function automatic logic [7:0] adr(input logic [2:0] s, input logic rd);
    return {IOXP_ADDR_FIXED, s, rd};
  endfunction : adr
  task automatic send(input logic [7:0] b, input logic ack);
    exp_q.push_back({1'b1, 7'h00, ack});
    u_ioxp_master_model.send_byte(b, dummy);
  endtask : send
  task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data);
    u_ioxp_master_model.bus_start();
    send(adr(strap, 1'b0), 1'b0);
    send(cmd, 1'b0);
    send(data, 1'b0);
    u_ioxp_master_model.bus_stop();
  endtask : write_reg
  // Command write, repeated start, then n reads of the same register
  task automatic read_reg(input logic [1:0] sel, input logic [7:0] exp, input int n);
    u_ioxp_master_model.bus_start();
    send(adr(strap, 1'b0), 1'b0);
    send({6'h00, sel}, 1'b0);
    u_ioxp_master_model.bus_start();
    send(adr(strap, 1'b1), 1'b0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({1'b0, exp});
      u_ioxp_master_model.recv_byte(i == n - 1);
    end
    u_ioxp_master_model.bus_stop();
  endtask : read_reg
  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : do_reset
  initial begin
    seed = 32'hd74e;
    sys_rst_i = 1'b1;
    strap = 3'h0;
    pins_ext = 8'h5A;
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    do_reset();
    check_byte("pin_enable", 8'h00, pins_oe);
    read_reg(IOXP_REG_OUTPUT, IOXP_RST_OUTPUT, 2);
    read_reg(IOXP_REG_INVERT, IOXP_RST_INVERT, 1);
    read_reg(IOXP_REG_DIR, IOXP_RST_DIR, 1);
    $display("test reset_values done");
    for (int s = 0; s < 8; s++) begin
      strap <= s[2:0];
      repeat (2) @(posedge clk_i);
      u_ioxp_master_model.bus_start();
      send(s[0] ? {4'h3, s[2:0], 1'b0} : adr(~s[2:0], 1'b0), 1'b1);
      send(8'h03, 1'b1);
      u_ioxp_master_model.bus_stop();
      write_reg({6'h00, IOXP_REG_INVERT}, {5'h00, s[2:0]});
    end
    read_reg(IOXP_REG_INVERT, 8'h07, 1);
    $display("test address done");
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    dir = 8'($random(seed));
    u_ioxp_master_model.bus_start();
    send(adr(strap, 1'b0), 1'b0);
    send({6'h3F, IOXP_REG_OUTPUT}, 1'b0);
    send(d1, 1'b0);
    send(d2, 1'b0);
    u_ioxp_master_model.bus_stop();
    write_reg({6'h00, IOXP_REG_DIR}, dir);
    repeat (4) @(posedge clk_i);
    check_byte("pin_enable", ~dir, pins_oe);
    check_byte("pin_drive", d2 & ~dir, pins_o & ~dir);
    pins_ext <= ~d2;
    read_reg(IOXP_REG_OUTPUT, d2, 1);
    $display("test drive done");
    inv = 8'($random(seed));
    write_reg({6'($random(seed)), IOXP_REG_INVERT}, inv);
    write_reg({6'h00, IOXP_REG_INPUT}, 8'($random(seed)));
    pins_ext <= 8'($random(seed));
    repeat (4) @(posedge clk_i);
    read_reg(IOXP_REG_INPUT, ((d2 & ~dir) | (pins_ext & dir)) ^ (inv & dir), 3);
    $display("test input_level done");
    do_reset();
    check_byte("pin_enable", 8'h00, pins_oe);
    read_reg(IOXP_REG_DIR, IOXP_RST_DIR, 1);
    read_reg(IOXP_REG_OUTPUT, IOXP_RST_OUTPUT, 1);
    $display("test second_reset done");
    repeat (4) @(posedge clk_i);
    end_of_test();
  end
endmodule : ioxp_top_bench
